// ### include/ssp_cfg.svh
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH
`define SSP_GANG_INDIVIDUAL 1'b0
`define SSP_GANG_GANGED 1'b1
`define SSP_AUTO_ENABLED 1'b0
`define SSP_AUTO_DISABLED 1'b1
`define SSP_TWI_SMBUS 1'b0
`define SSP_TWI_EEPROM 1'b1
`define SSP_NUM_PORTS 4
`define SSP_CDP_BLOCK_MASK 4'h1
`define SSP_PORTS_ALL 4'hf
`define SSP_PORTS_NONE 4'h0
`define SSP_ADDR_BIT 2
`define SSP_ADDR_RESET 7'h00
`endif

// ### include/ssp_pkg.sv
package ssp_pkg;
    typedef enum logic [1:0] {SSP_IN_RESET, SSP_CAPTURE, SSP_RUN} ssp_phase_type;
endpackage : ssp_pkg

// ### rtl/ssp_strap_hold.sv
`timescale 1ns/1ns
`include "ssp_cfg.svh"
// Holds one strap level; loads only on the capture strobe
module ssp_strap_hold
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic capture,
    input wire logic pin_level,
    input wire logic reset_value,
    output logic held
);
    logic loaded;
    logic value;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            loaded <= 1'b0;
            value <= 1'b0;
        end
        else if (capture)
        begin
            loaded <= 1'b1;
            value <= pin_level;
        end
    end
    assign held = loaded ? value : reset_value;
endmodule : ssp_strap_hold

// ### rtl/ssp_strap_status.sv
`timescale 1ns/1ns
`include "ssp_cfg.svh"
module ssp_strap_status
    import ssp_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic power_switch_enable,
    input wire logic hs_status_enable,
    input wire logic hs_upstream_connected,
    input wire logic hs_upstream_suspended,
    input wire logic upstream_attached,
    input wire logic [3:0] charge_port_enable,
    input wire logic gang_pin_in,
    output logic gang_pin_out,
    output logic gang_pin_oe,
    input wire logic auto_charge_disable_n_in,
    output logic auto_charge_disable_n_out,
    output logic auto_charge_disable_n_oe,
    input wire logic two_wire_mode_select,
    output logic power_ganged,
    output logic power_individual,
    output logic smbus_mode,
    output logic eeprom_mode,
    output logic [6:0] smbus_slave_addr,
    output logic smbus_addr_bit2_strap,
    output logic auto_charge_cfg_bit,
    output logic auto_charge_active,
    output logic [3:0] cdp_allowed
);
    ssp_phase_type phase;
    ssp_phase_type next_phase;
    logic capture;
    logic gang_held;
    logic auto_held;
    logic twi_held;
    logic running;
    logic next_auto_active;
    logic [3:0] next_cdp;
    logic [6:0] next_addr;

    function automatic logic [6:0] addr_with_bit2(input logic bit2);
        logic [6:0] a;
        a = `SSP_ADDR_RESET;
        a[`SSP_ADDR_BIT] = bit2;
        return a;
    endfunction : addr_with_bit2

    // First cycle after reset release is the sampling point
    always_comb
    begin
        unique case (phase)
            SSP_IN_RESET: next_phase = SSP_CAPTURE;
            SSP_CAPTURE: next_phase = SSP_RUN;
            SSP_RUN: next_phase = SSP_RUN;
        endcase
    end
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            phase <= SSP_IN_RESET;
        else
            phase <= next_phase;
    end
    assign capture = (phase == SSP_IN_RESET);
    assign running = (phase == SSP_RUN);

    ssp_strap_hold u_gang (.clk(clk), .reset_n(reset_n), .capture(capture),
        .pin_level(gang_pin_in), .reset_value(`SSP_GANG_INDIVIDUAL),
        .held(gang_held));
    ssp_strap_hold u_auto (.clk(clk), .reset_n(reset_n), .capture(capture),
        .pin_level(auto_charge_disable_n_in), .reset_value(`SSP_AUTO_DISABLED),
        .held(auto_held));
    ssp_strap_hold u_twi (.clk(clk), .reset_n(reset_n), .capture(capture),
        .pin_level(two_wire_mode_select), .reset_value(`SSP_TWI_EEPROM),
        .held(twi_held));

    assign next_auto_active = (auto_held == `SSP_AUTO_ENABLED) && !upstream_attached
        && running;
    assign next_cdp = next_auto_active ? (`SSP_PORTS_ALL & ~`SSP_CDP_BLOCK_MASK)
        : `SSP_PORTS_ALL;
    assign next_addr = (twi_held == `SSP_TWI_SMBUS) ? addr_with_bit2(gang_held)
        : `SSP_ADDR_RESET;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            power_ganged <= 1'b0;
            power_individual <= 1'b0;
            smbus_mode <= 1'b0;
            eeprom_mode <= 1'b0;
            smbus_slave_addr <= `SSP_ADDR_RESET;
            smbus_addr_bit2_strap <= 1'b0;
            auto_charge_cfg_bit <= `SSP_AUTO_DISABLED;
            auto_charge_active <= 1'b0;
            cdp_allowed <= `SSP_PORTS_ALL;
        end
        else
        begin
            power_ganged <= running && power_switch_enable
                && (gang_held == `SSP_GANG_GANGED);
            power_individual <= running && power_switch_enable
                && (gang_held == `SSP_GANG_INDIVIDUAL);
            smbus_mode <= running && (twi_held == `SSP_TWI_SMBUS);
            eeprom_mode <= running && (twi_held == `SSP_TWI_EEPROM);
            smbus_slave_addr <= running ? next_addr : `SSP_ADDR_RESET;
            smbus_addr_bit2_strap <= running && gang_held;
            auto_charge_cfg_bit <= auto_held;
            auto_charge_active <= next_auto_active;
            cdp_allowed <= next_cdp;
        end
    end

    // Pins stay inputs until strap sampling is over
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            gang_pin_oe <= 1'b0;
            gang_pin_out <= 1'b0;
            auto_charge_disable_n_oe <= 1'b0;
            auto_charge_disable_n_out <= 1'b0;
        end
        else
        begin
            gang_pin_oe <= running && hs_status_enable;
            gang_pin_out <= running && hs_status_enable
                && hs_upstream_connected;
            auto_charge_disable_n_oe <= running && hs_status_enable;
            auto_charge_disable_n_out <= running && hs_status_enable
                && hs_upstream_suspended;
        end
    end

    property p_gang_drive;
        @(posedge clk) disable iff (!reset_n)
        running && hs_status_enable |=> gang_pin_oe && (gang_pin_out == $past(hs_upstream_connected));
    endproperty
    a_gang_drive: assert property (p_gang_drive) else $error("hs connect pin wrong");
    property p_susp_drive;
        @(posedge clk) disable iff (!reset_n)
        running && hs_status_enable |=> auto_charge_disable_n_out == $past(hs_upstream_suspended);
    endproperty
    a_susp_drive: assert property (p_susp_drive) else $error("suspend pin wrong");
    property p_no_drive;
        @(posedge clk) disable iff (!reset_n)
        !hs_status_enable || !running |=> !gang_pin_oe && !auto_charge_disable_n_oe;
    endproperty
    a_no_drive: assert property (p_no_drive) else $error("pin driven while disabled");
    property p_gang_sample;
        @(posedge clk) disable iff (!reset_n)
        capture ##2 power_switch_enable |=> power_ganged == $past(gang_pin_in, 3);
    endproperty
    a_gang_sample: assert property (p_gang_sample) else $error("gang strap wrong");
    property p_indiv;
        @(posedge clk) disable iff (!reset_n)
        power_individual |-> !power_ganged;
    endproperty
    a_indiv: assert property (p_indiv) else $error("both power modes");
    property p_addr;
        @(posedge clk) disable iff (!reset_n)
        smbus_mode |-> smbus_slave_addr[`SSP_ADDR_BIT] == smbus_addr_bit2_strap;
    endproperty
    a_addr: assert property (p_addr) else $error("address bit2 wrong");
    property p_twi;
        @(posedge clk) disable iff (!reset_n)
        capture ##3 1'b1 |-> eeprom_mode == $past(two_wire_mode_select, 3) && (smbus_mode != eeprom_mode);
    endproperty
    a_twi: assert property (p_twi) else $error("two-wire mode wrong");
    property p_cdp;
        @(posedge clk) disable iff (!reset_n)
        auto_charge_active |-> !cdp_allowed[0];
    endproperty
    a_cdp: assert property (p_cdp) else $error("CDP on port 1 in auto mode");
    property p_auto_off;
        @(posedge clk) disable iff (!reset_n)
        auto_charge_cfg_bit |-> !auto_charge_active;
    endproperty
    a_auto_off: assert property (p_auto_off) else $error("auto mode while disabled");
    property p_cfg_seed;
        @(posedge clk) disable iff (!reset_n)
        capture ##2 1'b1 |-> auto_charge_cfg_bit == $past(auto_charge_disable_n_in, 2);
    endproperty
    a_cfg_seed: assert property (p_cfg_seed) else $error("cfg bit not seeded");
    property p_auto_on;
        @(posedge clk) disable iff (!reset_n)
        running && !auto_held && !upstream_attached |=> auto_charge_active;
    endproperty
    a_auto_on: assert property (p_auto_on) else $error("auto mode missing");

    c_ganged: cover property (@(posedge clk) power_ganged);
    c_auto: cover property (@(posedge clk) auto_charge_active);
    c_smbus: cover property (@(posedge clk) smbus_mode && smbus_addr_bit2_strap);
    c_status: cover property (@(posedge clk) gang_pin_out && auto_charge_disable_n_out);
endmodule : ssp_strap_status

// ### testbench/ssp_board_model.sv
`timescale 1ns/1ns
// Board straps with the pins' pulls; device drive wins while enabled
module ssp_board_model
(
    input wire logic gang_strap,
    input wire logic auto_strap,
    input wire logic gang_oe,
    input wire logic gang_out,
    input wire logic auto_oe,
    input wire logic auto_out,
    output logic gang_wire,
    output logic auto_wire,
    output logic test_pin
);
    assign gang_wire = gang_oe ? gang_out : gang_strap;
    assign auto_wire = auto_oe ? auto_out : auto_strap;
    assign test_pin = 1'b0;
endmodule : ssp_board_model

// ### testbench/testbench.sv
`timescale 1ns/1ns
module testbench import ssp_pkg::*;;
    logic clk = 1'b0, reset_n = 1'b0, pse = 1'b0, hse = 1'b0, conn = 1'b0, susp = 1'b0;
    logic att = 1'b0, g = 1'b0, a = 1'b1, m = 1'b0, gw, aw, go, goe, ao, aoe, tp;
    logic [3:0] cpe = 4'hf;
    logic pg, pi, sm, em, bit2, cfg, act;
    logic [6:0] addr;
    logic [3:0] cdp;
    int error_cnt = 0, num_checks = 0;
    always #25 clk = ~clk;
    ssp_board_model ssp_board_model_i (.gang_strap(g), .auto_strap(a), .gang_oe(goe),
        .gang_out(go), .auto_oe(aoe), .auto_out(ao), .gang_wire(gw), .auto_wire(aw),
        .test_pin(tp));
    ssp_strap_status ssp_strap_status_i (.clk(clk), .reset_n(reset_n),
        .power_switch_enable(pse), .hs_status_enable(hse), .hs_upstream_connected(conn),
        .hs_upstream_suspended(susp), .upstream_attached(att), .charge_port_enable(cpe),
        .gang_pin_in(gw), .gang_pin_out(go), .gang_pin_oe(goe),
        .auto_charge_disable_n_in(aw), .auto_charge_disable_n_out(ao),
        .auto_charge_disable_n_oe(aoe), .two_wire_mode_select(m), .power_ganged(pg),
        .power_individual(pi), .smbus_mode(sm), .eeprom_mode(em), .smbus_slave_addr(addr),
        .smbus_addr_bit2_strap(bit2), .auto_charge_cfg_bit(cfg), .auto_charge_active(act),
        .cdp_allowed(cdp));
    task automatic chk(input string name, input logic [6:0] exp, input logic [6:0] got);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    task automatic do_reset(input logic [3:0] v);
        @(posedge clk);
        reset_n <= 1'b0;
        {pse, m, a, g} <= v;
        repeat (3) @(posedge clk);
        #1;
        chk("gang_oe_rst", 7'h00, {6'h00, goe});
        @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
    endtask : do_reset
    // Every strap combination with and without power switching
    task automatic test_straps();
        for (int i = 0; i < 16; i++)
        begin
            do_reset(4'(i));
            chk("ganged", {6'h00, pse & g}, {6'h00, pg});
            chk("individual", {6'h00, pse & ~g}, {6'h00, pi});
            chk("smbus", {6'h00, ~m}, {6'h00, sm});
            chk("eeprom", {6'h00, m}, {6'h00, em});
            chk("addr", (~m & g) ? 7'h04 : 7'h00, addr);
            chk("bit2", {6'h00, g}, {6'h00, bit2});
            chk("cfg", {6'h00, a}, {6'h00, cfg});
            chk("auto", {6'h00, ~a}, {6'h00, act});
            chk("cdp", a ? 7'h0f : 7'h0e, {3'h0, cdp});
        end
    endtask : test_straps
    // Pin changes after sampling are ignored; attachment ends auto mode
    task automatic test_hold();
        do_reset(4'b1001);
        @(posedge clk);
        g <= 1'b0;
        a <= 1'b1;
        att <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk("hold_gang", 7'h01, {6'h00, pg});
        chk("hold_cfg", 7'h00, {6'h00, cfg});
        chk("auto_att", 7'h00, {6'h00, act});
    endtask : test_hold
    task automatic status_step(input logic e, c, s);
        @(posedge clk);
        hse <= e;
        conn <= c;
        susp <= s;
        repeat (3) @(posedge clk);
        #1;
        chk("gang_oe", {6'h00, e}, {6'h00, goe});
        chk("auto_oe", {6'h00, e}, {6'h00, aoe});
        if (e)
        begin
            chk("hs_conn", {6'h00, c}, {6'h00, go});
            chk("hs_susp", {6'h00, s}, {6'h00, ao});
        end
    endtask : status_step
    task automatic test_status();
        do_reset(4'b0000);
        status_step(1'b1, 1'b1, 1'b0);
        status_step(1'b1, 1'b0, 1'b1);
        status_step(1'b1, 1'b1, 1'b1);
        status_step(1'b0, 1'b1, 1'b1);
    endtask : test_status
    initial
    begin
        test_straps();
        test_hold();
        test_status();
        tally_and_finish();
    end
    initial
    begin
        #(4000 * 50);
        error_cnt++;
        tally_and_finish();
    end
endmodule : testbench
